// ---- fls_pkg.sv ----
// constants and types shared by both ends of the fuse, lock and signature readback path
package fls_pkg;
  // ----------------------------------------
  // clock and timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned WRITE_MIN_US = 3700;
  localparam int unsigned WRITE_MAX_US = 4500;
  localparam int unsigned WRITE_NOM_US = 4000;
  localparam int unsigned WRITE_CYCLES = WRITE_NOM_US * (CLK_HZ / 1_000_000);
  localparam logic [2:0] LOAD_WIN = 3'h3;
  localparam logic [2:0] STORE_WIN = 3'h4;
  // ----------------------------------------
  // control register fields
  // ----------------------------------------
  localparam int CB_EN = 0;
  localparam int CB_ERASE = 1;
  localparam int CB_PGWR = 2;
  localparam int CB_LRS = 3;
  localparam int CB_REEN = 4;
  localparam int CB_SIG = 5;
  localparam int CB_RWWB = 6;
  // ----------------------------------------
  // readback pointers and widths
  // ----------------------------------------
  localparam logic [15:0] PTR_FUSE_LOW = 16'h0000;
  localparam logic [15:0] PTR_LOCK = 16'h0001;
  localparam logic [15:0] PTR_FUSE_EXT = 16'h0002;
  localparam logic [15:0] PTR_FUSE_HIGH = 16'h0003;
  localparam logic [15:0] SIG_PTR_ID1 = 16'h0000;
  localparam logic [15:0] SIG_PTR_CAL = 16'h0001;
  localparam logic [15:0] SIG_PTR_ID2 = 16'h0002;
  localparam logic [15:0] SIG_PTR_ID3 = 16'h0004;
  localparam int LOCK_W = 6;
  localparam int EXT_W = 4;
  localparam logic [1:0] LOCK_TOP_FILL = 2'h3;
  localparam logic [3:0] EXT_TOP_FILL = 4'hF;
  localparam logic [7:0] RESERVED_READ = 8'hFF;
  // ----------------------------------------
  // host register word indices and fields
  // ----------------------------------------
  localparam logic [2:0] HR_CTRL = 3'h0;
  localparam logic [2:0] HR_PTR = 3'h1;
  localparam logic [2:0] HR_GO = 3'h2;
  localparam logic [2:0] HR_STORE = 3'h3;
  localparam logic [2:0] HR_RESULT = 3'h4;
  localparam logic [2:0] HR_STATUS = 3'h5;
  localparam int GO_READ = 0;
  localparam int GO_STORE = 1;
  localparam int GO_PLAIN = 2;
  localparam int ST_BUSY = 0;
  localparam int ST_EE = 1;
  localparam int ST_CTRL_LSB = 8;
  typedef enum logic [2:0] {
    FLS_IDLE = 3'b000,
    FLS_CHECK = 3'b001,
    FLS_CTRL = 3'b011,
    FLS_ISSUE = 3'b010,
    FLS_WAIT = 3'b110
  } fls_state_t;
endpackage

// ---- fls_if.sv ----
// link between the cpu-side controller and the readback device
`timescale 1ns/1ps
interface fls_if;
  logic ctrl_wr;
  logic [7:0] ctrl_wdata;
  logic [7:0] ctrl_rdata;
  logic [15:0] ptr;
  logic load_req;
  logic load_valid;
  logic [7:0] load_data;
  logic store_req;
  logic [15:0] store_data;
  logic ee_busy;
  modport dev (
    input ctrl_wr, ctrl_wdata, ptr, load_req, store_req, store_data,
    output ctrl_rdata, load_valid, load_data, ee_busy
  );
  modport cpu (
    output ctrl_wr, ctrl_wdata, ptr, load_req, store_req, store_data,
    input ctrl_rdata, load_valid, load_data, ee_busy
  );
endinterface

// ---- fls_device.sv ----
// readback device: control register, timed windows, fuse/lock/signature mux, write timer
`timescale 1ns/1ps
// Summary of operation
// - pointer 0x0001 armed load returns lock byte
// - lock bits sit in bits five to zero
// - lock select and enable auto-clear
// - disarmed load reads flash at pointer
// - pointer 0x0000 armed load returns fuse low
// - pointer 0x0003 armed load returns fuse high
// - pointer 0x0002 returns extended fuse, low nibble
// - programmed bits read zero, unprogrammed one
// - signature mode load returns signature row byte
// - signature select and enable auto-clear
// - identification bytes at 0x0000, 0x0002, 0x0004
// - signature pointer 0x0001 returns calibration byte
// - software uses only defined signature addresses
// - reset during write lets write finish
// - flash write lasts 3.7 to 4.5 ms
// - read-while-write busy held after programming
// - software waits for enable bit zero
// - software polls eeprom busy before sequence
// - eeprom write blocks programming and readback
// - re-enable clears busy after programming ends
module fls_device #(
  parameter logic [7:0] SIG_ID1 = 8'h5A, // arbitrary value
  parameter logic [7:0] SIG_ID2 = 8'hA5, // arbitrary value
  parameter logic [7:0] SIG_ID3 = 8'h3C, // arbitrary value
  parameter int unsigned WRITE_CYCLES = fls_pkg::WRITE_CYCLES
) (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RESET_N,
  // cpu link
  fls_if.dev BUS,
  // nonvolatile contents
  input wire logic [7:0] FUSE_LOW,
  input wire logic [7:0] FUSE_HIGH,
  input wire logic [fls_pkg::EXT_W-1:0] FUSE_EXT,
  input wire logic [fls_pkg::LOCK_W-1:0] LOCK_BITS,
  input wire logic [7:0] OSC_CAL,
  // eeprom status
  input wire logic EE_BUSY,
  // flash read port
  output logic [15:0] FLASH_ADDR,
  input wire logic [7:0] FLASH_RDATA,
  // write status
  output logic WRITE_BUSY,
  output logic RWW_BUSY
);
  import fls_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic selfprog_enable_q;
  logic erase_q;
  logic pgwr_q;
  logic lock_read_select_q;
  logic reenable_q;
  logic signature_read_select_q;
  logic readwhilewrite_busy_q;
  logic [2:0] load_cnt_q;
  logic [2:0] store_cnt_q;
  logic wr_busy_q;
  logic [31:0] wr_cnt_q;
  logic lock_op_q;
  logic [LOCK_W-1:0] lock_new_q;
  logic [LOCK_W-1:0] lock_prog_q;
  logic rd_pend_q;
  logic rd_rb_q;
  logic rd_lock_q;
  logic [15:0] rd_ptr_q;
  logic [15:0] flash_addr_q;
  logic [7:0] load_data_q;
  logic load_valid_q;
  logic ee_busy_q;
  logic [7:0] ctrl_rd;
  logic [7:0] rb_byte;
  logic [LOCK_W-1:0] lock_now;
  logic ctrl_take;
  logic load_win;
  logic rb_take;
  logic store_take;
  logic start_wr;
  logic load_expire;
  logic store_expire;
  logic wr_done;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  // eeprom blocks arming
  assign ctrl_take = BUS.ctrl_wr && !EE_BUSY && !selfprog_enable_q;
  assign load_win = selfprog_enable_q && (load_cnt_q != 3'h0) && (lock_read_select_q || signature_read_select_q);
  assign rb_take = BUS.load_req && load_win && !EE_BUSY;
  assign store_take = BUS.store_req && selfprog_enable_q && (store_cnt_q != 3'h0) && !wr_busy_q
                      && !signature_read_select_q && !EE_BUSY;
  assign start_wr = store_take && (erase_q || pgwr_q || lock_read_select_q);
  assign load_expire = (load_cnt_q == 3'h1) && !rb_take;
  assign store_expire = (store_cnt_q == 3'h1) && !store_take;
  assign wr_done = wr_busy_q && (wr_cnt_q == 32'h1);
  assign lock_now = LOCK_BITS & ~lock_prog_q;

  // ----------------------------------------
  // control register bits
  // ----------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (wr_busy_q) begin
      if (wr_done) begin
        selfprog_enable_q <= 1'b0;
        erase_q <= 1'b0;
        pgwr_q <= 1'b0;
        lock_read_select_q <= 1'b0;
      end
    end else if (!RESET_N) begin
      selfprog_enable_q <= 1'b0;
      erase_q <= 1'b0;
      pgwr_q <= 1'b0;
      lock_read_select_q <= 1'b0;
      reenable_q <= 1'b0;
      signature_read_select_q <= 1'b0;
      readwhilewrite_busy_q <= 1'b0;
    end else if (ctrl_take) begin
      selfprog_enable_q <= BUS.ctrl_wdata[CB_EN];
      erase_q <= BUS.ctrl_wdata[CB_ERASE];
      pgwr_q <= BUS.ctrl_wdata[CB_PGWR];
      lock_read_select_q <= BUS.ctrl_wdata[CB_LRS];
      reenable_q <= BUS.ctrl_wdata[CB_REEN];
      signature_read_select_q <= BUS.ctrl_wdata[CB_SIG];
    end else if (rb_take) begin
      selfprog_enable_q <= 1'b0;
      lock_read_select_q <= 1'b0;
      signature_read_select_q <= 1'b0;
      erase_q <= 1'b0;
      pgwr_q <= 1'b0;
      reenable_q <= 1'b0;
    end else if (store_take) begin
      selfprog_enable_q <= start_wr;
      reenable_q <= 1'b0;
      if (erase_q || pgwr_q) begin
        readwhilewrite_busy_q <= 1'b1;
      end else if (reenable_q) begin
        readwhilewrite_busy_q <= 1'b0;
      end
    end else if (load_expire && signature_read_select_q) begin
      selfprog_enable_q <= 1'b0;
      signature_read_select_q <= 1'b0;
    end else if (store_expire && !signature_read_select_q) begin
      selfprog_enable_q <= 1'b0;
      lock_read_select_q <= 1'b0;
      erase_q <= 1'b0;
      pgwr_q <= 1'b0;
      reenable_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // timed windows
  // ----------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      load_cnt_q <= 3'h0;
      store_cnt_q <= 3'h0;
    end else if (ctrl_take) begin
      load_cnt_q <= LOAD_WIN;
      store_cnt_q <= STORE_WIN;
    end else if (rb_take || store_take) begin
      load_cnt_q <= 3'h0;
      store_cnt_q <= 3'h0;
    end else begin
      if (load_cnt_q != 3'h0) begin
        load_cnt_q <= load_cnt_q - 3'h1;
      end
      if (store_cnt_q != 3'h0) begin
        store_cnt_q <= store_cnt_q - 3'h1;
      end
    end
  end

  // ----------------------------------------
  // flash write timer
  // ----------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (wr_busy_q) begin
      wr_cnt_q <= wr_cnt_q - 32'h1;
      if (wr_done) begin
        wr_busy_q <= 1'b0;
        lock_op_q <= 1'b0;
        if (lock_op_q) begin
          lock_prog_q <= lock_prog_q | ~lock_new_q;
        end
      end
    end else if (!RESET_N) begin
      wr_busy_q <= 1'b0;
      wr_cnt_q <= 32'h0;
      lock_op_q <= 1'b0;
      lock_new_q <= '1;
      lock_prog_q <= '0;
    end else if (start_wr) begin
      wr_busy_q <= 1'b1;
      wr_cnt_q <= WRITE_CYCLES;
      lock_op_q <= lock_read_select_q;
      lock_new_q <= BUS.store_data[LOCK_W-1:0];
    end
  end

  // ----------------------------------------
  // readback byte
  // ----------------------------------------
  always_comb begin
    rb_byte = RESERVED_READ;
    if (rd_lock_q) begin
      case (rd_ptr_q)
        PTR_LOCK: rb_byte = {LOCK_TOP_FILL, lock_now};
        PTR_FUSE_LOW: rb_byte = FUSE_LOW;
        PTR_FUSE_HIGH: rb_byte = FUSE_HIGH;
        PTR_FUSE_EXT: rb_byte = {EXT_TOP_FILL, FUSE_EXT};
        default: rb_byte = RESERVED_READ;
      endcase
    end else begin
      case (rd_ptr_q)
        SIG_PTR_ID1: rb_byte = SIG_ID1;
        SIG_PTR_ID2: rb_byte = SIG_ID2;
        SIG_PTR_ID3: rb_byte = SIG_ID3;
        SIG_PTR_CAL: rb_byte = OSC_CAL;
        default: rb_byte = RESERVED_READ;
      endcase
    end
  end

  // ----------------------------------------
  // load response pipeline
  // ----------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      rd_pend_q <= 1'b0;
      rd_rb_q <= 1'b0;
      rd_lock_q <= 1'b0;
      rd_ptr_q <= 16'h0000;
      flash_addr_q <= 16'h0000;
      load_valid_q <= 1'b0;
      load_data_q <= 8'h00;
    end else begin
      rd_pend_q <= BUS.load_req;
      load_valid_q <= rd_pend_q;
      if (BUS.load_req) begin
        rd_rb_q <= rb_take;
        rd_lock_q <= lock_read_select_q;
        rd_ptr_q <= BUS.ptr;
        flash_addr_q <= BUS.ptr;
      end
      if (rd_pend_q) begin
        load_data_q <= rd_rb_q ? rb_byte : FLASH_RDATA;
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      ee_busy_q <= 1'b0;
    end else begin
      ee_busy_q <= EE_BUSY;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  always_comb begin
    ctrl_rd = 8'h00;
    ctrl_rd[CB_EN] = selfprog_enable_q;
    ctrl_rd[CB_ERASE] = erase_q;
    ctrl_rd[CB_PGWR] = pgwr_q;
    ctrl_rd[CB_LRS] = lock_read_select_q;
    ctrl_rd[CB_REEN] = reenable_q;
    ctrl_rd[CB_SIG] = signature_read_select_q;
    ctrl_rd[CB_RWWB] = readwhilewrite_busy_q;
  end

  assign BUS.ctrl_rdata = ctrl_rd;
  assign BUS.load_valid = load_valid_q;
  assign BUS.load_data = load_data_q;
  assign BUS.ee_busy = ee_busy_q;
  assign FLASH_ADDR = flash_addr_q;
  assign WRITE_BUSY = wr_busy_q;
  assign RWW_BUSY = readwhilewrite_busy_q;
endmodule // fls_device

// ---- fls_host.sv ----
// cpu-side controller: avalon register slave that runs timed load and store sequences
`timescale 1ns/1ps
module fls_host (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RESET_N,
  // avalon slave
  input wire logic [2:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // device link
  fls_if.cpu BUS
);
  import fls_pkg::*;

  fls_state_t state_q;
  logic wait_q;
  logic [31:0] readdata_q;
  logic [7:0] ctrl_val_q;
  logic [15:0] ptr_q;
  logic [15:0] store_q;
  logic [7:0] result_q;
  logic op_store_q;
  logic ctrl_wr_q;
  logic load_req_q;
  logic store_req_q;
  logic req;
  logic acc_wr;
  logic go;
  logic [31:0] rd_mux;

  // ----------------------------------------
  // avalon slave
  // ----------------------------------------
  assign req = AVS_READ || AVS_WRITE;
  assign acc_wr = AVS_WRITE && !wait_q;
  assign go = acc_wr && (AVS_ADDRESS == HR_GO) && (state_q == FLS_IDLE);

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (AVS_ADDRESS)
      HR_CTRL: rd_mux[7:0] = ctrl_val_q;
      HR_PTR: rd_mux[15:0] = ptr_q;
      HR_STORE: rd_mux[15:0] = store_q;
      HR_RESULT: rd_mux[7:0] = result_q;
      HR_STATUS: begin
        rd_mux[ST_BUSY] = (state_q != FLS_IDLE);
        rd_mux[ST_EE] = BUS.ee_busy;
        rd_mux[ST_CTRL_LSB +: 8] = BUS.ctrl_rdata;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      wait_q <= 1'b1;
      readdata_q <= 32'h0000_0000;
    end else begin
      wait_q <= !(req && wait_q);
      if (AVS_READ && wait_q) begin
        readdata_q <= rd_mux;
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      ctrl_val_q <= 8'h00;
      ptr_q <= 16'h0000;
      store_q <= 16'h0000;
    end else if (acc_wr) begin
      case (AVS_ADDRESS)
        HR_CTRL: ctrl_val_q <= AVS_WRITEDATA[7:0];
        HR_PTR: ptr_q <= AVS_WRITEDATA[15:0];
        HR_STORE: store_q <= AVS_WRITEDATA[15:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      state_q <= FLS_IDLE;
      op_store_q <= 1'b0;
      ctrl_wr_q <= 1'b0;
      load_req_q <= 1'b0;
      store_req_q <= 1'b0;
      result_q <= 8'h00;
    end else begin
      unique case (state_q)
        FLS_IDLE: begin
          if (go) begin
            op_store_q <= AVS_WRITEDATA[GO_STORE] && !AVS_WRITEDATA[GO_PLAIN];
            if (AVS_WRITEDATA[GO_PLAIN]) begin
              load_req_q <= 1'b1;
              state_q <= FLS_ISSUE;
            end else if (AVS_WRITEDATA[GO_READ] || AVS_WRITEDATA[GO_STORE]) begin
              state_q <= FLS_CHECK;
            end
          end
        end
        FLS_CHECK: begin
          if (!BUS.ctrl_rdata[CB_EN] && !BUS.ee_busy) begin
            ctrl_wr_q <= 1'b1;
            state_q <= FLS_CTRL;
          end
        end
        FLS_CTRL: begin
          ctrl_wr_q <= 1'b0;
          load_req_q <= !op_store_q;
          store_req_q <= op_store_q;
          state_q <= FLS_ISSUE;
        end
        FLS_ISSUE: begin
          load_req_q <= 1'b0;
          store_req_q <= 1'b0;
          state_q <= op_store_q ? FLS_IDLE : FLS_WAIT;
        end
        FLS_WAIT: begin
          if (BUS.load_valid) begin
            result_q <= BUS.load_data;
            state_q <= FLS_IDLE;
          end
        end
        default: state_q <= FLS_IDLE;
      endcase
    end
  end

  assign AVS_READDATA = readdata_q;
  assign AVS_WAITREQUEST = wait_q;
  assign BUS.ctrl_wr = ctrl_wr_q;
  assign BUS.ctrl_wdata = ctrl_val_q;
  assign BUS.ptr = ptr_q;
  assign BUS.load_req = load_req_q;
  assign BUS.store_req = store_req_q;
  assign BUS.store_data = store_q;
endmodule // fls_host

// ---- fls_readback_props.sv ----
// assertions on the link between the controller and the readback device
`timescale 1ns/1ps
module fls_readback_props (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RESET_N,
  // link signals
  input wire logic ctrl_wr,
  input wire logic [7:0] ctrl_rdata,
  input wire logic [15:0] ptr,
  input wire logic load_req,
  input wire logic load_valid,
  input wire logic [7:0] load_data,
  input wire logic store_req,
  input wire logic ee_busy
);
  import fls_pkg::*;
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESET_N);
  logic en;
  assign en = ctrl_rdata[CB_EN];
  AST_LOAD_ANSWER: assert property (load_req |-> ##2 load_valid)
    else $error("load answer not two cycles after request");
  AST_VALID_CAUSE: assert property (load_valid |-> $past(load_req, 2))
    else $error("load answer without request");
  AST_DATA_HOLD: assert property (!load_valid && $past(RESET_N) |-> $stable(load_data))
    else $error("load data changed without answer");
  AST_LOCK_CLEAR: assert property ($rose(en) && !ctrl_rdata[CB_SIG] |-> ##[0:4] (!en || store_req))
    else $error("enable still set after store window");
  AST_SIG_CLEAR: assert property ($rose(en) && ctrl_rdata[CB_SIG] |-> ##[1:3] !en)
    else $error("signature enable still set after load window");
  AST_READBACK_CLEAR: assert property (load_req && en && (ctrl_rdata[CB_LRS] || ctrl_rdata[CB_SIG]) && !ee_busy
    |=> !en)
    else $error("enable not cleared by readback");
  AST_LOCK_TOP: assert property (load_valid && $past(en && ctrl_rdata[CB_LRS], 2) && $past(ptr, 2) == 16'h0001
    |-> load_data[7:6] == 2'h3)
    else $error("lock byte top bits wrong");
  AST_EXT_TOP: assert property (load_valid && $past(en && ctrl_rdata[CB_LRS], 2) && $past(ptr, 2) == 16'h0002
    |-> load_data[7:4] == 4'hF)
    else $error("extended fuse top bits wrong");
  cover property (load_valid && $past(en && ctrl_rdata[CB_SIG], 2));
  cover property (store_req && ctrl_rdata[CB_ERASE]);
  cover property (ctrl_wr ##2 !en);
endmodule // fls_readback_props

// ---- fuse_lock_signature_readback_test.sv ----
// self-checking bench: both ends joined, avalon stimulus, queued result checks
`timescale 1ns/1ps
module fuse_lock_signature_readback_test;
  import fls_pkg::*;
  // ----------------------------------------
  // settings and signals
  // ----------------------------------------
  localparam logic [7:0] ID1 = 8'h96; // arbitrary value
  localparam logic [7:0] ID2 = 8'h69; // arbitrary value
  localparam logic [7:0] ID3 = 8'hC3; // arbitrary value
  localparam int unsigned WCYC = 20;
  logic ref_clk;
  logic reset_n;
  logic [2:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [7:0] fuse_low;
  logic [7:0] fuse_high;
  logic [3:0] fuse_ext;
  logic [5:0] lock_bits;
  logic [7:0] osc_cal;
  logic ee_busy_in;
  logic [15:0] flash_addr;
  logic [7:0] flash_rdata;
  logic write_busy;
  logic rww_busy;
  logic [5:0] lock_exp;
  logic [5:0] st_bits;
  logic [31:0] rdat;
  logic chk_rd;
  logic [7:0] exp_q[$];
  int miscompares;
  int cmp_count;
  int wb_cnt = 0;
  int wb0;
  logic [15:0] pv;
  fls_if bus_if();
  // ----------------------------------------
  // both ends and checker
  // ----------------------------------------
  fls_device #(.SIG_ID1(ID1), .SIG_ID2(ID2), .SIG_ID3(ID3), .WRITE_CYCLES(WCYC)) i_fls_device (
    .REF_CLK(ref_clk), .RESET_N(reset_n), .BUS(bus_if.dev), .FUSE_LOW(fuse_low), .FUSE_HIGH(fuse_high),
    .FUSE_EXT(fuse_ext), .LOCK_BITS(lock_bits), .OSC_CAL(osc_cal), .EE_BUSY(ee_busy_in),
    .FLASH_ADDR(flash_addr), .FLASH_RDATA(flash_rdata), .WRITE_BUSY(write_busy), .RWW_BUSY(rww_busy));
  fls_host i_fls_host (.REF_CLK(ref_clk), .RESET_N(reset_n), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
    .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata), .AVS_READDATA(avs_readdata),
    .AVS_WAITREQUEST(avs_waitrequest), .BUS(bus_if.cpu));
  fls_readback_props i_fls_readback_props (.REF_CLK(ref_clk), .RESET_N(reset_n), .ctrl_wr(bus_if.ctrl_wr),
    .ctrl_rdata(bus_if.ctrl_rdata), .ptr(bus_if.ptr), .load_req(bus_if.load_req),
    .load_valid(bus_if.load_valid), .load_data(bus_if.load_data), .store_req(bus_if.store_req),
    .ee_busy(bus_if.ee_busy));
  assign flash_rdata = flash_addr[7:0] ^ flash_addr[15:8] ^ 8'h5C;
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic av(input logic wr, input logic [2:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    rdat = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic wait_idle();
    do av(1'b0, HR_STATUS, 32'h0); while (rdat[ST_BUSY] !== 1'b0 || rdat[ST_CTRL_LSB + CB_EN] !== 1'b0);
  endtask
  task automatic run(input logic [7:0] c, input logic [15:0] p, input logic [2:0] go, input logic [15:0] st);
    av(1'b1, HR_PTR, {16'h0, p});
    av(1'b1, HR_CTRL, {24'h0, c});
    av(1'b1, HR_STORE, {16'h0, st});
    av(1'b1, HR_GO, {29'h0, go});
    wait_idle();
  endtask
  task automatic rd_result(input logic [7:0] e);
    exp_q.push_back(e);
    chk_rd <= 1'b1;
    av(1'b0, HR_RESULT, 32'h0);
    chk_rd <= 1'b0;
  endtask
  function automatic logic [7:0] exp_of(input logic sig, input logic [15:0] p);
    if (sig) begin
      case (p)
        16'h0000: return ID1;
        16'h0001: return osc_cal;
        16'h0002: return ID2;
        16'h0004: return ID3;
        default: return 8'hFF;
      endcase
    end
    case (p)
      16'h0000: return fuse_low;
      16'h0001: return {2'h3, lock_exp};
      16'h0002: return {4'hF, fuse_ext};
      default: return fuse_high;
    endcase
  endfunction
  // ----------------------------------------
  // monitors and watchdog
  // ----------------------------------------
  always @(posedge ref_clk) begin
    if (avs_read && !avs_waitrequest && chk_rd) begin
      chk("result", avs_readdata[7:0], exp_q.pop_front());
    end
    if (write_busy === 1'b1) begin
      wb_cnt <= wb_cnt + 1;
    end
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    miscompares++;
    finish_test();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    reset_n = 1'b0;
    {avs_address, avs_read, avs_write, avs_writedata, ee_busy_in, chk_rd} = '0;
    {miscompares, cmp_count} = '0;
    void'($urandom(57));
    {fuse_low, fuse_high, fuse_ext, lock_bits, osc_cal} = 34'($urandom) ^ {2'h0, 32'($urandom)};
    lock_exp = lock_bits;
    repeat (20) @(posedge ref_clk);
    reset_n <= 1'b1;
    av(1'b0, HR_STATUS, 32'h0);
    chk("status after reset", rdat, 32'h0);
    av(1'b0, 3'h6, 32'h0);
    chk("unmapped read", rdat, 32'h0);
    for (int i = 0; i < 4; i++) begin
      run(8'h09, 16'(i), 3'h1, 16'h0);
      rd_result(exp_of(1'b0, 16'(i)));
    end
    for (int i = 0; i < 4; i++) begin
      run(8'h21, 16'(i + i / 3), 3'h1, 16'h0);
      rd_result(exp_of(1'b1, 16'(i + i / 3)));
    end
    av(1'b1, HR_RESULT, 32'hAA);
    rd_result(ID3);
    for (int i = 0; i < 3; i++) begin
      pv = 16'($urandom);
      run(8'h09, pv, 3'h4, 16'h0);
      rd_result(pv[7:0] ^ pv[15:8] ^ 8'h5C);
    end
    run(8'h21, 16'h0000, 3'h2, 16'h0);
    chk("ctrl after sig timeout", rdat[15:8], 32'h0);
    chk("sig store refused", write_busy, 32'h0);
    ee_busy_in <= 1'b1;
    av(1'b1, HR_PTR, 32'h0);
    av(1'b1, HR_CTRL, 32'h09);
    av(1'b1, HR_GO, 32'h1);
    repeat (10) @(posedge ref_clk);
    av(1'b0, HR_STATUS, 32'h0);
    chk("status in eeprom write", rdat[15:0], 32'h0003);
    ee_busy_in <= 1'b0;
    wait_idle();
    rd_result(fuse_low);
    av(1'b1, HR_CTRL, 32'h03);
    av(1'b1, HR_GO, 32'h2);
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    chk("busy after reset", {write_busy, rww_busy}, 32'h3);
    wait_idle();
    run(8'h05, 16'h0000, 3'h2, 16'h0);
    chk("rww busy after write", rww_busy, 32'h1);
    run(8'h11, 16'h0000, 3'h2, 16'h0);
    chk("rww busy after reenable", rww_busy, 32'h0);
    run(8'h01, 16'h0000, 3'h2, 16'h0);
    chk("fill store", {write_busy, rww_busy}, 32'h0);
    st_bits = 6'($urandom);
    wb0 = wb_cnt;
    run(8'h09, 16'h0001, 3'h2, {10'h3FF, st_bits});
    chk("write length", (wb_cnt - wb0) >= WCYC && (wb_cnt - wb0) <= WCYC + 1, 32'h1);
    lock_exp = lock_bits & st_bits;
    run(8'h09, 16'h0001, 3'h1, 16'h0);
    rd_result(exp_of(1'b0, 16'h0001));
    finish_test();
  end
endmodule // fuse_lock_signature_readback_test
